/* core/tra_pkg.sv */
// constants and types shared by the read-out amplifier control core
package tra_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int T_NORMAL_DELAY_US = 3000;
  localparam int NORMAL_DELAY_CYC = T_NORMAL_DELAY_US * CLK_MHZ;
  localparam int T_DEBOUNCE_US = 1000;
  localparam int DEBOUNCE_CYC = T_DEBOUNCE_US * CLK_MHZ;
  // output time switch positions 0..2; position 3 is hold_until_cleared
  localparam int T_OUT0_MS = 10;
  localparam int T_OUT1_MS = 50;
  localparam int T_OUT2_MS = 500;
  localparam int OUT0_CYC = T_OUT0_MS * 1000 * CLK_MHZ;
  localparam int OUT1_CYC = T_OUT1_MS * 1000 * CLK_MHZ;
  localparam int OUT2_CYC = T_OUT2_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 27;
  localparam logic [1:0] OUT_SEL_HOLD = 2'h3;

  // ---------------------------------------------------------------------------
  // address limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_MAX_SRAM = 8'hFF;
  localparam logic [7:0] ADDR_MAX_EEPROM = 8'hFD;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_ERR = 4'hC;
  localparam int CFG_EEPROM_BIT = 0;
  localparam int CFG_SOFT_INHIBIT_BIT = 1;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_OUTSEL_LSB = 1;
  localparam int STAT_ARMED_BIT = 3;
  localparam int STAT_NORMAL_BIT = 4;
  localparam int STAT_ERR_BIT = 5;
  localparam int STAT_PRESENT_BIT = 6;
  localparam int STAT_STATE_LSB = 8;

  // ---------------------------------------------------------------------------
  // error code bits
  // ---------------------------------------------------------------------------
  localparam int ERR_XFER_BIT = 0;
  localparam int ERR_NO_CARRIER_BIT = 2;
  localparam int ERR_ADDR_BIT = 3;

  localparam logic MODE_FREE_RUN = 1'b0;
  localparam logic MODE_TRIGGERED = 1'b1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_OK = 5'b01000,
    ST_FAIL = 5'b10000
  } tra_state_t;

endpackage

/* core/tra_debounce.sv */
// synchroniser and debouncer for one external input, with edge pulses
`timescale 1ns/100ps
`default_nettype none
module tra_debounce
  import tra_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic level_q, level_d;
  logic rise_q, rise_d;
  logic fall_q, fall_d;
  logic [TMR_W-1:0] cnt_q, cnt_d;

  always_comb
  begin
    meta_d = i_pin;
    sync_d = meta_q;
    level_d = level_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    cnt_d = '0;
    // level accepted only after it stays put for the whole window
    if (sync_q != level_q)
    begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q >= TMR_W'(STABLE_CYC - 1))
      begin
        level_d = sync_q;
        rise_d = sync_q;
        fall_d = ~sync_q;
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      cnt_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      level_q <= level_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_level = level_q;
  assign o_rise = rise_q;
  assign o_fall = fall_q;

endmodule
`default_nettype wire

/* core/tra_core.sv */
// read-out amplifier control: switch straps, read sequencing, result outputs, avalon registers
`timescale 1ns/100ps
`default_nettype none
module tra_core
  import tra_pkg::*;
#(
  parameter int NORMAL_DELAY = NORMAL_DELAY_CYC,
  parameter int OUT_TIME0 = OUT0_CYC,
  parameter int OUT_TIME1 = OUT1_CYC,
  parameter int OUT_TIME2 = OUT2_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // switches and host pins
  input wire logic [3:0] i_addr_sw_hi,
  input wire logic [3:0] i_addr_sw_lo,
  input wire logic i_mode_sw,
  input wire logic [1:0] i_out_time_sw,
  input wire logic i_read_request_in,
  input wire logic i_inhibit_in,
  input wire logic i_carrier_present,
  output logic [7:0] o_data,
  output logic o_normal,
  output logic o_error,
  // carrier transfer engine, same clock
  output logic o_cr_req,
  output logic [7:0] o_cr_addr,
  input wire logic i_cr_done,
  input wire logic i_cr_ok,
  input wire logic [7:0] i_cr_data,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);

  // ---------------------------------------------------------------------------
  // pin conditioning
  // ---------------------------------------------------------------------------
  localparam int NPIN = 3;
  logic [NPIN-1:0] pin_raw, pin_lvl, pin_rise, pin_fall;
  assign pin_raw = {i_carrier_present, i_inhibit_in, i_read_request_in};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_pin
      tra_debounce #(
        .STABLE_CYC(DEBOUNCE)
      ) u_deb (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(pin_raw[gi]),
        .o_level(pin_lvl[gi]),
        .o_rise(pin_rise[gi]),
        .o_fall(pin_fall[gi])
      );
    end
  endgenerate

  logic trig_rise, inh_rise, inh_fall, inh_lvl, car_lvl, car_fall;
  assign trig_rise = pin_rise[0];
  assign inh_rise = pin_rise[1];
  assign inh_fall = pin_fall[1];
  assign inh_lvl = pin_lvl[1];
  assign car_lvl = pin_lvl[2];
  assign car_fall = pin_fall[2];

  // switches are static pins but still cross into the clock domain
  logic [11:0] sw_meta_q, sw_sync_q;
  always_ff @(posedge i_clk)
  begin
    sw_meta_q <= {i_addr_sw_hi, i_addr_sw_lo, i_mode_sw, i_out_time_sw, 1'b0};
    sw_sync_q <= sw_meta_q;
  end

  // ---------------------------------------------------------------------------
  // power-up straps
  // ---------------------------------------------------------------------------
  // mode and output time taken a few cycles after reset so the synchroniser is settled; address follows the switches every cycle
  logic [1:0] strap_wait_q, strap_wait_d;
  logic straps_done_q, straps_done_d;
  logic mode_q, mode_d;
  logic [1:0] out_sel_q, out_sel_d;
  logic [7:0] addr_q, addr_d;

  always_comb
  begin
    strap_wait_d = strap_wait_q;
    straps_done_d = straps_done_q;
    mode_d = mode_q;
    out_sel_d = out_sel_q;
    addr_d = {sw_sync_q[11:8], sw_sync_q[7:4]};
    if (!straps_done_q)
    begin
      strap_wait_d = strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h3)
      begin
        straps_done_d = 1'b1;
        mode_d = sw_sync_q[3];
        out_sel_d = sw_sync_q[2:1];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      strap_wait_q <= 2'h0;
      straps_done_q <= 1'b0;
      mode_q <= MODE_FREE_RUN;
      out_sel_q <= 2'h0;
      addr_q <= 8'h00;
    end
    else
    begin
      strap_wait_q <= strap_wait_d;
      straps_done_q <= straps_done_d;
      mode_q <= mode_d;
      out_sel_q <= out_sel_d;
      addr_q <= addr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration register (software)
  // ---------------------------------------------------------------------------
  logic [1:0] cfg_q, cfg_d;
  logic eeprom_type, inhibit_any;
  assign eeprom_type = cfg_q[CFG_EEPROM_BIT];
  assign inhibit_any = inh_lvl | cfg_q[CFG_SOFT_INHIBIT_BIT];

  function automatic logic addr_ok(input logic [7:0] a, input logic eeprom);
    addr_ok = eeprom ? (a <= ADDR_MAX_EEPROM) : (a <= ADDR_MAX_SRAM);
  endfunction

  function automatic logic [TMR_W-1:0] out_time(input logic [1:0] sel);
    unique case (sel)
      2'h0: out_time = TMR_W'(OUT_TIME0);
      2'h1: out_time = TMR_W'(OUT_TIME1);
      2'h2: out_time = TMR_W'(OUT_TIME2);
      default: out_time = '0;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // read sequencer
  // ---------------------------------------------------------------------------
  tra_state_t state_q, state_d;
  logic armed_q, armed_d;
  logic [7:0] data_q, data_d;
  logic [7:0] err_code_q, err_code_d;
  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic clear_evt, hold_mode, start_auto;

  assign hold_mode = (out_sel_q == OUT_SEL_HOLD);
  // the clear is the inhibit in free-running, the trigger in triggered mode
  assign clear_evt = (mode_q == MODE_FREE_RUN) ? inh_rise : trig_rise;
  assign start_auto = (mode_q == MODE_FREE_RUN) && armed_q && car_lvl && !inhibit_any;

  always_comb
  begin
    state_d = state_q;
    data_d = data_q;
    err_code_d = err_code_q;
    tmr_d = tmr_q;
    // re-arm once the carrier has gone or inhibit has been let go
    armed_d = armed_q | car_fall | inh_fall | !car_lvl;
    unique case (state_q)
      ST_IDLE:
      begin
        if (straps_done_q
          && (start_auto || (mode_q == MODE_TRIGGERED && trig_rise)))
        begin
          armed_d = 1'b0;
          err_code_d = 8'h00;
          if (!car_lvl || !addr_ok(addr_q, eeprom_type))
          begin
            err_code_d[ERR_NO_CARRIER_BIT] = !car_lvl;
            err_code_d[ERR_ADDR_BIT] = car_lvl;
            data_d = 8'h00;
            tmr_d = out_time(out_sel_q);
            state_d = ST_FAIL;
          end
          else
          begin
            state_d = ST_READ;
          end
        end
      end
      ST_READ:
      begin
        if (i_cr_done)
        begin
          if (i_cr_ok)
          begin
            data_d = i_cr_data;
            tmr_d = TMR_W'(NORMAL_DELAY - 1);
            state_d = ST_DELAY;
          end
          else
          begin
            err_code_d[ERR_XFER_BIT] = 1'b1;
            data_d = 8'h00;
            tmr_d = out_time(out_sel_q);
            state_d = ST_FAIL;
          end
        end
      end
      ST_DELAY:
      begin
        tmr_d = tmr_q - 1'b1;
        if (tmr_q == '0)
        begin
          tmr_d = out_time(out_sel_q);
          state_d = ST_OK;
        end
      end
      ST_OK, ST_FAIL:
      begin
        // result held for the selected time, or until cleared in hold mode
        if (hold_mode && clear_evt)
        begin
          state_d = ST_IDLE;
        end
        else if (!hold_mode)
        begin
          tmr_d = tmr_q - 1'b1;
          if (tmr_q <= TMR_W'(1))
          begin
            state_d = ST_IDLE;
          end
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_q <= ST_IDLE;
      armed_q <= 1'b1;
      data_q <= 8'h00;
      err_code_q <= 8'h00;
      tmr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      armed_q <= armed_d;
      data_q <= data_d;
      err_code_q <= err_code_d;
      tmr_q <= tmr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // host outputs
  // ---------------------------------------------------------------------------
  // only pass/fail is signalled on the host pins; armed, state and carrier present leave only via the avalon status word
  logic [7:0] out_data_q, out_data_d;
  logic normal_q, normal_d;
  logic error_q, error_d;

  always_comb
  begin
    out_data_d = inhibit_any ? 8'h00 : data_q;
    normal_d = (state_q == ST_OK);
    error_d = (state_q == ST_FAIL);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      out_data_q <= 8'h00;
      normal_q <= 1'b0;
      error_q <= 1'b0;
    end
    else
    begin
      out_data_q <= out_data_d;
      normal_q <= normal_d;
      error_q <= error_d;
    end
  end

  assign o_data = out_data_q;
  assign o_normal = normal_q;
  assign o_error = error_q;
  assign o_cr_req = (state_q == ST_READ);
  assign o_cr_addr = addr_q;

  // ---------------------------------------------------------------------------
  // avalon-mm register slave
  // ---------------------------------------------------------------------------
  // fixed latency: waitrequest drops on the second cycle of each request
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = '0;
    status_word[STAT_MODE_BIT] = mode_q;
    status_word[STAT_OUTSEL_LSB +: 2] = out_sel_q;
    status_word[STAT_ARMED_BIT] = armed_q;
    status_word[STAT_NORMAL_BIT] = normal_q;
    status_word[STAT_ERR_BIT] = error_q;
    status_word[STAT_PRESENT_BIT] = car_lvl;
    status_word[STAT_STATE_LSB +: 5] = state_q;
  end

  always_comb
  begin
    ack_d = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    cfg_d = cfg_q;
    if (i_avs_read && !ack_q)
    begin
      unique case (i_avs_address)
        REG_CFG: rdata_d = {30'h0, cfg_q};
        REG_STATUS: rdata_d = status_word;
        REG_DATA: rdata_d = {24'h0, data_q};
        REG_ERR: rdata_d = {16'h0, addr_q, err_code_q};
        default: rdata_d = 32'h0;
      endcase
    end
    if (i_avs_write && ack_q && i_avs_address == REG_CFG)
    begin
      cfg_d = i_avs_writedata[1:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      cfg_q <= CFG_RESET;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      cfg_q <= cfg_d;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata = rdata_q;

endmodule
`default_nettype wire

/* tb/tra_core_checker.sv */
// concurrent checks on the read-out amplifier control core ports
`timescale 1ns/100ps
`default_nettype none
module tra_core_checker
#(
  parameter int NORMAL_DELAY = 20
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr_sw_hi,
  input wire logic [3:0] i_addr_sw_lo,
  input wire logic i_cr_done,
  input wire logic i_cr_ok,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [7:0] o_data,
  input wire logic o_normal,
  input wire logic o_error,
  input wire logic o_cr_req,
  input wire logic [7:0] o_cr_addr,
  input wire logic o_avs_waitrequest
);
  // ---------------------------------------------------------------------------
  // cycles since the last good transfer
  // ---------------------------------------------------------------------------
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  always_comb
  begin
    gap_d = gap_q + 16'h1;
    if (i_sys_rst || (i_cr_done && i_cr_ok))
      gap_d = 16'h0;
  end
  always_ff @(posedge i_clk)
  begin
    gap_q <= gap_d;
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_off_on_error: assert property (o_error && $past(o_error) |-> o_data == 8'h00)
    else $error("data lines on during error");
  chk_one_result: assert property (!(o_normal && o_error))
    else $error("success and failure together");
  chk_req_addr: assert property (o_cr_req |-> o_cr_addr == {i_addr_sw_hi, i_addr_sw_lo})
    else $error("carrier address differs from switches");
  chk_req_holds: assert property (o_cr_req && !i_cr_done |=> o_cr_req)
    else $error("read request dropped early");
  chk_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest)
    else $error("bus wait longer than one cycle");
  chk_normal_delay: assert property ($rose(o_normal)
    |-> gap_q >= NORMAL_DELAY + 1 && gap_q <= NORMAL_DELAY + 4)
    else $error("success output at wrong delay");
  chk_reset_quiet: assert property (disable iff (1'b0) i_sys_rst
    |=> !o_normal && !o_error && !o_cr_req && o_data == 8'h00)
    else $error("outputs active after reset");
  chk_idle_req: assert property (o_cr_req |-> !o_normal && !o_error)
    else $error("read started while result shown");
endmodule
bind tra_core tra_core_checker #(.NORMAL_DELAY(NORMAL_DELAY)) u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_addr_sw_hi(i_addr_sw_hi), .i_addr_sw_lo(i_addr_sw_lo),
  .i_cr_done(i_cr_done), .i_cr_ok(i_cr_ok), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_data(o_data), .o_normal(o_normal), .o_error(o_error),
  .o_cr_req(o_cr_req), .o_cr_addr(o_cr_addr), .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

/* tb/tra_carrier_model.sv */
// carrier transfer engine model: answers a read request after a latency
`timescale 1ns/100ps
`default_nettype none
module tra_carrier_model
#(
  parameter int LAT = 5
)
(
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [7:0] i_addr,
  input wire logic i_fail,
  output logic o_done,
  output logic o_ok,
  output logic [7:0] o_data
);
  int cnt = 0;
  logic busy = 1'b0;
  initial
  begin
    o_done = 1'b0;
    o_ok = 1'b0;
    o_data = 8'h00;
  end
  always @(posedge i_clk)
  begin
    o_done <= 1'b0;
    o_ok <= 1'b0;
    // byte only valid with done; toggles otherwise
    o_data <= ~o_data;
    if (!i_req)
    begin
      busy <= 1'b0;
      cnt <= 0;
    end
    else if (!busy && cnt == LAT)
    begin
      o_done <= 1'b1;
      o_ok <= !i_fail;
      o_data <= i_addr ^ 8'hA5;
      busy <= 1'b1;
    end
    else if (!busy)
      cnt <= cnt + 1;
  end
endmodule
`default_nettype wire

/* tb/tag_read_amplifier_control_tb.sv */
// self-checking bench for the read-out amplifier control core
`timescale 1ns/100ps
`default_nettype none
module tag_read_amplifier_control_tb;
  localparam int ND = 20;
  localparam int T0 = 30;
  localparam int T1 = 40;
  localparam int T2 = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sw = 8'h00;
  logic mode = 1'b0;
  logic [1:0] ots = 2'h0;
  logic read_request_in = 1'b0;
  logic inh = 1'b0;
  logic pres = 1'b0;
  logic fail = 1'b0;
  logic [3:0] a_addr = 4'h0;
  logic a_rd = 1'b0;
  logic a_wr = 1'b0;
  logic [31:0] a_wd = 32'h0;
  logic [31:0] a_rdata;
  logic a_wait;
  logic [7:0] data;
  logic normal;
  logic err;
  logic req;
  logic [7:0] cr_addr;
  logic cr_done;
  logic cr_ok;
  logic [7:0] cr_data;
  logic req_prev = 1'b0;
  int n_req = 0;
  int n_errors = 0;
  int samples_checked = 0;
  tra_core #(.NORMAL_DELAY(ND), .OUT_TIME0(T0), .OUT_TIME1(T1), .OUT_TIME2(T2),
    .DEBOUNCE(4)) DUT (.i_clk(clk), .i_sys_rst(rst), .i_addr_sw_hi(sw[7:4]),
    .i_addr_sw_lo(sw[3:0]), .i_mode_sw(mode), .i_out_time_sw(ots),
    .i_read_request_in(read_request_in), .i_inhibit_in(inh), .i_carrier_present(pres),
    .o_data(data), .o_normal(normal), .o_error(err), .o_cr_req(req),
    .o_cr_addr(cr_addr), .i_cr_done(cr_done), .i_cr_ok(cr_ok), .i_cr_data(cr_data),
    .i_avs_address(a_addr), .i_avs_read(a_rd), .i_avs_write(a_wr),
    .i_avs_writedata(a_wd), .o_avs_readdata(a_rdata), .o_avs_waitrequest(a_wait));
  tra_carrier_model #(.LAT(5)) u_car (.i_clk(clk), .i_req(req), .i_addr(cr_addr),
    .i_fail(fail), .o_done(cr_done), .o_ok(cr_ok), .o_data(cr_data));
  initial
  begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    req_prev <= req;
    if (req && !req_prev)
      n_req <= n_req + 1;
  end
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic do_reset(input logic m, input logic [1:0] s);
    @(posedge clk);
    mode <= m;
    ots <= s;
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(20);
  endtask
  // one avalon transfer; returns at the edge that completes it
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    a_addr <= a;
    a_wd <= wd;
    a_wr <= wr;
    a_rd <= !wr;
    do
    begin
      @(posedge clk);
      n++;
    end while (a_wait !== 1'b0 && n < 50);
    // waitrequest seen low at this edge: write lands and read data stands here
    rd = a_rdata;
    a_rd <= 1'b0;
    a_wr <= 1'b0;
    if (n >= 50)
    begin
      check("bus timeout", 0, 1);
      results();
    end
  endtask
  // waits for a result, or for new data when dat is set
  task automatic wait_res(output int n, input bit dat);
    n = 0;
    while ((dat ? data === 8'h00 : !(normal || err)) && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      check("result timeout", 0, 1);
      results();
    end
  endtask
  task automatic width(input int exp);
    int n;
    n = 0;
    while ((normal || err) && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    check("output time", exp, n);
  endtask
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic sc_trig();
    logic [31:0] r;
    int g;
    do_reset(1'b1, 2'h0);
    sw <= 8'h5B;
    pres <= 1'b1;
    cyc(20);
    check("idle outputs", 0, {normal, err, data});
    bus(0, 4'h4, 0, r);
    check("mode latched", 1, r[0]);
    bus(0, 4'h2, 0, r);
    check("unmapped read", 0, r);
    @(posedge clk);
    mode <= 1'b0;
    cyc(30);
    check("no read untriggered", 0, n_req);
    read_request_in <= 1'b1;
    wait_res(g, 1);
    wait_res(g, 0);
    check("success delay", 1, g >= ND - 1 && g <= ND + 1);
    check("read byte", 8'h5B ^ 8'hA5, data);
    check("success out", 1, normal);
    width(T0);
    check("data held", 8'h5B ^ 8'hA5, data);
    check("one attempt", 1, n_req);
    bus(0, 4'h8, 0, r);
    check("data register", 8'h5B ^ 8'hA5, r);
    @(posedge clk);
    read_request_in <= 1'b0;
    cyc(20);
  endtask
  task automatic sc_fail();
    logic [31:0] r;
    int g;
    do_reset(1'b1, 2'h2);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      pres <= k[0];
      fail <= 1'b1;
      cyc(20);
      read_request_in <= 1'b1;
      wait_res(g, 0);
      check("failure out", 1, err);
      check("data off", 0, data);
      width(T2);
      bus(0, 4'hC, 0, r);
      check("error code", k ? 8'h01 : 8'h04, r[7:0]);
      @(posedge clk);
      read_request_in <= 1'b0;
      cyc(20);
    end
    fail <= 1'b0;
  endtask
  task automatic sc_eeprom();
    logic [31:0] r;
    int g;
    do_reset(1'b1, 2'h1);
    bus(1, 4'h0, 1, r);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      sw <= k ? 8'hFD : 8'hFE;
      pres <= 1'b1;
      cyc(20);
      read_request_in <= 1'b1;
      wait_res(g, 0);
      check("limit result", k ? 2'b10 : 2'b01, {normal, err});
      check("limit data", k ? 8'hFD ^ 8'hA5 : 8'h00, data);
      width(T1);
      @(posedge clk);
      read_request_in <= 1'b0;
      cyc(20);
    end
  endtask
  task automatic sc_free();
    logic [31:0] r;
    int g;
    int n0;
    pres <= 1'b0;
    sw <= 8'h3C;
    do_reset(1'b0, 2'h3);
    pres <= 1'b1;
    wait_res(g, 0);
    check("auto read", 8'h3C ^ 8'hA5, data);
    n0 = n_req;
    cyc(100);
    check("held result", 1, normal);
    check("no reread", n0, n_req);
    inh <= 1'b1;
    cyc(20);
    check("cleared", 0, {normal, err, data});
    inh <= 1'b0;
    wait_res(g, 0);
    check("rearmed read", n0 + 1, n_req);
    check("rearmed data", 8'h3C ^ 8'hA5, data);
    // software inhibit masks the lines without rearming a read
    bus(1, 4'h0, 32'h2, r);
    cyc(2);
    check("soft inhibit", 0, data);
    bus(1, 4'h0, 32'h0, r);
    cyc(2);
    check("soft inhibit off", 8'h3C ^ 8'hA5, data);
    check("no reread soft", n0 + 1, n_req);
  endtask
  initial
  begin
    sc_trig();
    sc_fail();
    sc_eeprom();
    sc_free();
    results();
  end
endmodule
`default_nettype wire
